/* File: vacuum_ejector_control.sv */
/*
  Control logic of a compressed-air vacuum ejector: nozzle and blow-off
  valve drive, air-saving regulation, threshold LEDs, bar display and
  feedback output, with a small register port for parameters.
  Assumes command pins are asynchronous and the vacuum sample arrives on
  the core clock with a valid strobe.
  // What this block does
  // RULE_01 - NO variant: command asserted turns nozzle off
  // RULE_02 - NC variant: command asserted turns nozzle on
  // RULE_03 - Suction: nozzle off at control threshold
  // RULE_04 - Nozzle back on below threshold minus hysteresis
  // RULE_05 - External blow-off follows blow-off command
  // RULE_06 - Internal blow-off runs timed after suction
  // RULE_07 - Decisions use the sampled vacuum value
  // RULE_08 - Eight segment bar shows vacuum always
  // RULE_09 - Suction and blow-off state LEDs
  // RULE_10 - Both threshold LEDs dark below output threshold
  // RULE_11 - Only output LED between thresholds
  // RULE_12 - Both threshold LEDs above control threshold
  // RULE_13 - Reset enters automatic mode, obeys commands
  // RULE_14 - Manual mode: keypad drives suction, blow-off
  // RULE_15 - Parameter changes only in automatic mode
  // RULE_16 - Feedback output with output threshold hysteresis
  // RULE_17 - Maximum control threshold disables regulation
  // RULE_18 - Reject control threshold not above output
  // RULE_19 - Nonzero blow time selects internal blow-off
  // RULE_20 - Synchronise commands; blow-off beats suction
*/
`timescale 1ns/100ps
`default_nettype none

module vacuum_ejector_control #(
  parameter int unsigned MS_CYCLES = vacuum_ejector_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [vacuum_ejector_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [vacuum_ejector_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [vacuum_ejector_pkg::DATA_W-1:0] reg_rdata_o,
  // Command pins from the machine controller
  input wire logic suck_cmd_i,
  input wire logic blow_cmd_i,
  // Vacuum sensor sample, mbar
  input wire logic [vacuum_ejector_pkg::VAC_W-1:0] vac_sample_i,
  input wire logic vac_valid_i,
  // Valves and feedback
  output logic nozzle_valve_o,
  output logic blow_valve_o,
  output logic feedback_o,
  // Display
  output logic led_suction_o,
  output logic led_blow_o,
  output logic led_control_o,
  output logic led_output_o,
  output logic [7:0] bar_o
);

  import vacuum_ejector_pkg::*;

  // Lower switching point of the control threshold: 20 % below it,
  // but not below the output threshold plus the minimum gap, and never above the control threshold itself.
  function automatic logic [9:0] control_low(input logic [9:0] ctl, input logic [9:0] outp);
    logic [9:0] low;
    logic [10:0] floor_v;
    low = ctl - (ctl / CONTROL_HYST_DIV);
    floor_v = {1'b0, outp} + CONTROL_MIN_GAP;
    if (floor_v > {1'b0, ctl}) begin
      low = ctl;
    end else if (floor_v > {1'b0, low}) begin
      low = floor_v[9:0];
    end
    return low;
  endfunction : control_low

  function automatic logic [9:0] output_low(input logic [9:0] outp);
    return (outp > OUTPUT_HYSTERESIS) ? (outp - OUTPUT_HYSTERESIS) : 10'h000;
  endfunction : output_low

  // Register state
  logic variant_nc_q;
  logic manual_q;
  logic man_suck_q;
  logic man_blow_q;
  logic reject_q;
  logic [9:0] control_threshold_q;
  logic [9:0] output_threshold_q;
  logic [15:0] blow_time_q;
  logic [9:0] vac_q;

  // Core state
  eject_state_t state_q;
  eject_state_t state_d;
  logic hold_q;
  logic ctl_on_q;
  logic out_on_q;
  logic [15:0] blow_left_q;
  logic blow_load;
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [7:0] blink_cnt_q;
  logic blink_q;
  logic [1:0] cmd_sync;
  logic [1:0] cmd_prev_q;

  // Decoded conditions
  logic wr_ctrl;
  logic wr_param;
  logic timed;
  logic reg_disabled;
  logic suction_req;
  logic ext_blow;
  logic [9:0] ctl_low;
  logic [9:0] out_low;
  logic [7:0] bar_d;

  // RULE_20 command sync
  cmd_sync u_cmd_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({blow_cmd_i, suck_cmd_i}),
    .sync_o(cmd_sync)
  );

  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  // RULE_15 automatic mode only
  assign wr_param = reg_wr_i && !manual_q;
  // RULE_19 timed when nonzero
  assign timed = (blow_time_q != 16'h0000);
  // RULE_17 maximum disables regulation
  assign reg_disabled = (control_threshold_q == CONTROL_THRESHOLD_MAX);
  assign ctl_low = control_low(control_threshold_q, output_threshold_q);
  assign out_low = output_low(output_threshold_q);

  // RULE_01 NO variant inverts command
  // RULE_02 NC variant follows command
  // RULE_14 manual keypad request
  always_comb begin
    if (manual_q) begin
      suction_req = man_suck_q;
    end else if (variant_nc_q) begin
      suction_req = cmd_sync[0];
    end else begin
      suction_req = !cmd_sync[0];
    end
  end

  // RULE_05 external blow-off request
  // Held manual blow-off button acts like the external input
  assign ext_blow = manual_q ? man_blow_q : (cmd_sync[1] && !timed);

  // Millisecond enable, restarted when a timed blow-off loads
  assign ms_tick = (ms_cnt_q == (MS_CYCLES - 32'd1));

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ms_cnt_q <= 32'h0000_0000;
    end else if (ms_tick || blow_load) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blink_cnt_q <= 8'h00;
      blink_q <= 1'b0;
    end else if (ms_tick) begin
      if (blink_cnt_q == BLINK_HALF_MS - 8'h01) begin
        blink_cnt_q <= 8'h00;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 8'h01;
      end
    end
  end

  // RULE_07 latch sampled vacuum
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vac_q <= 10'h000;
    end else if (vac_valid_i) begin
      vac_q <= vac_sample_i;
    end
  end

  // Process state machine
  always_comb begin
    state_d = state_q;
    blow_load = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // RULE_20 blow-off first
        if (ext_blow) begin
          state_d = ST_BLOW;
        end else if (suction_req) begin
          state_d = ST_SUCTION;
        end
      end
      ST_SUCTION: begin
        if (ext_blow) begin
          state_d = ST_BLOW;
        end else if (!suction_req) begin
          // RULE_06 timed blow on leaving
          if (timed) begin
            state_d = ST_BLOW;
            blow_load = 1'b1;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_BLOW: begin
        // RULE_05 blow while commanded
        if (!ext_blow && (blow_left_q == 16'h0000)) begin
          state_d = suction_req ? ST_SUCTION : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // RULE_13 reset to automatic idle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // RULE_06 blow-off duration count
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blow_left_q <= 16'h0000;
    end else if (blow_load) begin
      blow_left_q <= blow_time_q;
    end else if (state_q != ST_BLOW) begin
      blow_left_q <= 16'h0000;
    end else if (ms_tick && (blow_left_q != 16'h0000)) begin
      blow_left_q <= blow_left_q - 16'h0001;
    end
  end

  // Air-saving regulation; small volumes may overshoot before the cut
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_q <= 1'b0;
    end else if ((state_q != ST_SUCTION) || reg_disabled) begin
      hold_q <= 1'b0;
    end else if (vac_q >= control_threshold_q) begin
      // RULE_03 cut at threshold
      hold_q <= 1'b1;
    end else if (vac_q < ctl_low) begin
      // RULE_04 resume below hysteresis
      hold_q <= 1'b0;
    end
  end

  // RULE_10 dark below output point
  // RULE_16 output threshold hysteresis
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_on_q <= 1'b0;
    end else if (vac_q > output_threshold_q) begin
      out_on_q <= 1'b1;
    end else if (vac_q < out_low) begin
      out_on_q <= 1'b0;
    end
  end

  // RULE_12 control threshold hysteresis
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_on_q <= 1'b0;
    end else if (vac_q > control_threshold_q) begin
      ctl_on_q <= 1'b1;
    end else if (vac_q < ctl_low) begin
      ctl_on_q <= 1'b0;
    end
  end

  // RULE_08 eight segment bar
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bar_d[i] = (vac_q >= BAR_LEVELS[i]);
    end
  end

  // Output registers; threshold LEDs flash together in manual mode
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nozzle_valve_o <= 1'b0;
      blow_valve_o <= 1'b0;
      feedback_o <= 1'b0;
      led_suction_o <= 1'b0;
      led_blow_o <= 1'b0;
      led_control_o <= 1'b0;
      led_output_o <= 1'b0;
      bar_o <= 8'h00;
    end else begin
      nozzle_valve_o <= (state_q == ST_SUCTION) && !hold_q;
      blow_valve_o <= (state_q == ST_BLOW);
      // RULE_16 feedback follows output point
      feedback_o <= out_on_q;
      // RULE_09 process state LEDs
      led_suction_o <= (state_q == ST_SUCTION);
      led_blow_o <= (state_q == ST_BLOW);
      // RULE_11 output LED between thresholds
      led_control_o <= manual_q ? blink_q : ctl_on_q;
      led_output_o <= manual_q ? blink_q : (out_on_q || ctl_on_q);
      bar_o <= bar_d;
    end
  end

  // RULE_14 manual mode entry and exit
  // Entry always starts pneumatically off; a change on either command pin
  // drops back to automatic mode, which can move the handled part.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      manual_q <= 1'b0;
      man_suck_q <= 1'b0;
      man_blow_q <= 1'b0;
      cmd_prev_q <= 2'h0;
    end else begin
      cmd_prev_q <= cmd_sync;
      if (manual_q && (cmd_sync != cmd_prev_q)) begin
        manual_q <= 1'b0;
        man_suck_q <= 1'b0;
        man_blow_q <= 1'b0;
      end else if (wr_ctrl) begin
        manual_q <= reg_wdata_i[CTRL_MANUAL];
        if (manual_q && reg_wdata_i[CTRL_MANUAL]) begin
          man_suck_q <= reg_wdata_i[CTRL_MAN_SUCK];
          man_blow_q <= reg_wdata_i[CTRL_MAN_BLOW];
        end else begin
          man_suck_q <= 1'b0;
          man_blow_q <= 1'b0;
        end
      end
    end
  end

  // Parameter registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      variant_nc_q <= RST_VARIANT_NC;
      control_threshold_q <= RST_CONTROL_THRESHOLD;
      output_threshold_q <= RST_OUTPUT_THRESHOLD;
      blow_time_q <= RST_BLOW_TIME;
    end else if (wr_param) begin
      case (reg_addr_i)
        OFS_CTRL: begin
          variant_nc_q <= reg_wdata_i[CTRL_VARIANT_NC];
        end
        OFS_CONTROL_THRESHOLD: begin
          // RULE_18 must exceed output point
          if (reg_wdata_i[9:0] > output_threshold_q) begin
            control_threshold_q <= reg_wdata_i[9:0];
          end
        end
        OFS_OUTPUT_THRESHOLD: begin
          if (reg_wdata_i[9:0] < control_threshold_q) begin
            output_threshold_q <= reg_wdata_i[9:0];
          end
        end
        OFS_BLOW_TIME: begin
          blow_time_q <= reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // RULE_18 sticky reject flag
  // Rejection sets it; a new rejection in the clearing cycle wins.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reject_q <= 1'b0;
    end else if (reg_wr_i && manual_q && (reg_addr_i != OFS_CTRL) && (reg_addr_i != OFS_STATUS)
                 && (reg_addr_i != OFS_VACUUM)) begin
      reject_q <= 1'b1;
    end else if (wr_param && (reg_addr_i == OFS_CONTROL_THRESHOLD)
                 && (reg_wdata_i[9:0] <= output_threshold_q)) begin
      reject_q <= 1'b1;
    end else if (wr_param && (reg_addr_i == OFS_OUTPUT_THRESHOLD)
                 && (reg_wdata_i[9:0] >= control_threshold_q)) begin
      reject_q <= 1'b1;
    end else if (wr_ctrl && reg_wdata_i[CTRL_REJECT_CLR]) begin
      reject_q <= 1'b0;
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      case (reg_addr_i)
        OFS_CTRL: begin
          reg_rdata_o <= {12'h000, man_blow_q, man_suck_q, manual_q, variant_nc_q};
        end
        OFS_CONTROL_THRESHOLD: begin
          reg_rdata_o <= {6'h00, control_threshold_q};
        end
        OFS_OUTPUT_THRESHOLD: begin
          reg_rdata_o <= {6'h00, output_threshold_q};
        end
        OFS_BLOW_TIME: begin
          reg_rdata_o <= blow_time_q;
        end
        OFS_STATUS: begin
          reg_rdata_o <= {4'h0, cmd_sync, (out_on_q || ctl_on_q), ctl_on_q, out_on_q, timed,
                          reject_q, hold_q, manual_q, state_q};
        end
        OFS_VACUUM: begin
          reg_rdata_o <= {6'h00, vac_q};
        end
        default: begin
          reg_rdata_o <= 16'h0000;
        end
      endcase
    end
  end

endmodule : vacuum_ejector_control

`default_nettype wire

/* File: vacuum_ejector_pkg.sv */
/*
  Constants for the vacuum ejector controller: register offsets, field
  positions, reset values, threshold arithmetic and timing counts.
  Assumes a 125 MHz core clock and a 10-bit vacuum sample in mbar.
*/
`default_nettype none

package vacuum_ejector_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned VAC_W = 10;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONTROL_THRESHOLD = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_THRESHOLD = 8'h08;
  localparam logic [7:0] OFS_BLOW_TIME = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_VACUUM = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_VARIANT_NC = 0;
  localparam int unsigned CTRL_MANUAL = 1;
  localparam int unsigned CTRL_MAN_SUCK = 2;
  localparam int unsigned CTRL_MAN_BLOW = 3;
  localparam int unsigned CTRL_REJECT_CLR = 4;

  // Status register fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_MANUAL = 3;
  localparam int unsigned ST_HOLD = 4;
  localparam int unsigned ST_REJECT = 5;
  localparam int unsigned ST_TIMED = 6;
  localparam int unsigned ST_FEEDBACK = 7;
  localparam int unsigned ST_LED_CTL = 8;
  localparam int unsigned ST_LED_OUT = 9;
  localparam int unsigned ST_CMD_LSB = 10;

  // Values after reset
  localparam logic [9:0] RST_CONTROL_THRESHOLD = 10'h226;
  localparam logic [9:0] RST_OUTPUT_THRESHOLD = 10'h0c8;
  localparam logic [15:0] RST_BLOW_TIME = 16'h0000;
  localparam logic RST_VARIANT_NC = 1'b1;

  // Threshold arithmetic in mbar, except the hysteresis divisor
  localparam logic [9:0] CONTROL_THRESHOLD_MAX = 10'h3ff;
  localparam logic [9:0] CONTROL_HYST_DIV = 10'h005;
  localparam logic [10:0] CONTROL_MIN_GAP = 11'h019;
  localparam logic [9:0] OUTPUT_HYSTERESIS = 10'h00a;

  // Bar segment switch-on levels in mbar, segment 0 first
  localparam logic [9:0] BAR_LEVELS [8] = '{10'h064, 10'h0c8, 10'h12c, 10'h190,
                                            10'h226, 10'h28a, 10'h2ee, 10'h352};

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] BLINK_HALF_MS = 8'hfa;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SUCTION = 3'b010,
    ST_BLOW    = 3'b100
  } eject_state_t;

endpackage : vacuum_ejector_pkg

`default_nettype wire

/* File: cmd_sync.sv */
/*
  Two-flop synchroniser for the two discrete command pins.
  Assumes the pins are asynchronous to the core clock.
*/
`timescale 1ns/100ps
`default_nettype none

module cmd_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Pins and synchronised levels
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);

  logic [1:0] meta_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 2'h0;
      sync_o <= 2'h0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : cmd_sync

`default_nettype wire

/* File: controller_model.sv */
/*
  Machine controller model: drives the two command pins and a sensor stream.
  Assumes the bench sets the requested levels just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module controller_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Requests from the bench
  input wire logic suck_req_i,
  input wire logic blow_req_i,
  input wire logic [vacuum_ejector_pkg::VAC_W-1:0] vac_level_i,
  // Pins and sensor stream
  output logic suck_cmd_o,
  output logic blow_cmd_o,
  output logic [vacuum_ejector_pkg::VAC_W-1:0] vac_sample_o,
  output logic vac_valid_o
);
  import vacuum_ejector_pkg::*;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      suck_cmd_o <= 1'b0;
      blow_cmd_o <= 1'b0;
      vac_valid_o <= 1'b0;
      vac_sample_o <= '0;
    end else begin
      suck_cmd_o <= suck_req_i;
      blow_cmd_o <= blow_req_i;
      vac_valid_o <= ~vac_valid_o;
      // Between strobes the line shows junk, so a stale latch is caught
      vac_sample_o <= vac_valid_o ? ~vac_level_i : vac_level_i;
    end
  end
endmodule : controller_model

`default_nettype wire

/* File: vacuum_ejector_control_sva.sv */
/*
  Port-level properties of the ejector controller.
  Assumes one clock and an async active-high reset; bound at the foot.
*/
`timescale 1ns/100ps
`default_nettype none

module vacuum_ejector_checker
  import vacuum_ejector_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [vacuum_ejector_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [vacuum_ejector_pkg::DATA_W-1:0] reg_rdata_o,
  // Sensor
  input wire logic [vacuum_ejector_pkg::VAC_W-1:0] vac_sample_i,
  input wire logic vac_valid_i,
  // Valves and display
  input wire logic nozzle_valve_o,
  input wire logic blow_valve_o,
  input wire logic feedback_o,
  input wire logic led_suction_o,
  input wire logic led_blow_o,
  input wire logic [7:0] bar_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_sample_then_read;
    vac_valid_i ##1 (reg_rd_i && reg_addr_i == OFS_VACUUM && !vac_valid_i);
  endsequence
  sequence s_low_twice;
    (vac_valid_i && vac_sample_i < BAR_LEVELS[0]) ##1 !vac_valid_i
      ##1 (vac_valid_i && vac_sample_i < BAR_LEVELS[0]);
  endsequence

  AST_RESET_QUIET: assert property ($fell(sys_rst_i) |-> !nozzle_valve_o && !blow_valve_o
    && !feedback_o && !led_suction_o && !led_blow_o && bar_o == 8'h00)
    else $error("outputs not quiet at reset release");
  AST_SYNC_DELAY: assert property ($fell(sys_rst_i) |=> !nozzle_valve_o && !blow_valve_o)
    else $error("valve moved before command sync");
  AST_STATE_LEDS_EXCL: assert property (!(led_suction_o && led_blow_o))
    else $error("suction and blow LEDs lit together");
  AST_BLOW_LED_FOLLOWS: assert property (led_blow_o == blow_valve_o)
    else $error("blow LED differs from blow valve");
  AST_NOZZLE_IN_SUCTION: assert property (nozzle_valve_o |-> led_suction_o)
    else $error("nozzle on outside suction state");
  AST_BAR_THERMO: assert property (((bar_o + 8'h01) & bar_o) == 8'h00)
    else $error("bar not a contiguous run from segment 0");
  AST_BAR_LOW: assert property (s_low_twice |=> bar_o == 8'h00)
    else $error("bar lit below lowest level");
  AST_VAC_READBACK: assert property (s_sample_then_read |=>
    reg_rdata_o == {6'h00, $past(vac_sample_i, 2)})
    else $error("vacuum readback not the latched sample");
endmodule : vacuum_ejector_checker

bind vacuum_ejector_control vacuum_ejector_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .vac_sample_i(vac_sample_i),
  .vac_valid_i(vac_valid_i), .nozzle_valve_o(nozzle_valve_o), .blow_valve_o(blow_valve_o),
  .feedback_o(feedback_o), .led_suction_o(led_suction_o), .led_blow_o(led_blow_o), .bar_o(bar_o));

`default_nettype wire

/* File: testbench.sv */
/*
  Self-checking bench for the ejector controller.
  Assumes the controller model drives pins and sensor; 1 ms is 10 cycles here.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import vacuum_ejector_pkg::*;
  logic core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, suck_req, blow_req, vac_valid_i;
  logic suck_cmd_i, blow_cmd_i, nozzle_valve_o, blow_valve_o, feedback_o;
  logic led_suction_o, led_blow_o, led_control_o, led_output_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, rd;
  logic [VAC_W-1:0] vac_level, vac_sample_i;
  logic [7:0] bar_o;
  logic [6:0] outs;
  int fails, n_tests, cnt;

  assign outs = {nozzle_valve_o, blow_valve_o, led_suction_o, led_blow_o, feedback_o, led_control_o, led_output_o};

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  vacuum_ejector_control #(.MS_CYCLES(10)) dut_u (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .suck_cmd_i(suck_cmd_i),
    .blow_cmd_i(blow_cmd_i), .vac_sample_i(vac_sample_i), .vac_valid_i(vac_valid_i),
    .nozzle_valve_o(nozzle_valve_o), .blow_valve_o(blow_valve_o), .feedback_o(feedback_o),
    .led_suction_o(led_suction_o), .led_blow_o(led_blow_o), .led_control_o(led_control_o),
    .led_output_o(led_output_o), .bar_o(bar_o));

  controller_model ctl_u (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .suck_req_i(suck_req), .blow_req_i(blow_req),
    .vac_level_i(vac_level), .suck_cmd_o(suck_cmd_i), .blow_cmd_o(blow_cmd_i),
    .vac_sample_o(vac_sample_i), .vac_valid_o(vac_valid_i));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic expect_reg(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
    check(what, rd, exp);
  endtask : expect_reg

  // Pins pass model, two sync flops, state and output register
  task automatic drive(input logic s, input logic b, input logic [9:0] v, input logic [6:0] exp);
    @(posedge core_clk_i);
    suck_req <= s;
    blow_req <= b;
    vac_level <= v;
    repeat (9) @(posedge core_clk_i);
    #1 check("outs", {9'h000, outs}, {9'h000, exp});
  endtask : drive

  initial begin
    #(8 * 5000);
    fails++;
    tally_and_finish();
  end

  initial begin
    {sys_rst_i, fails, n_tests} = '0;
    sys_rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, suck_req, blow_req} = 4'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    vac_level = 10'h000;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    expect_reg("ctrl", OFS_CTRL, 16'h0001);
    expect_reg("ctl_thr", OFS_CONTROL_THRESHOLD, 16'h0226);
    expect_reg("out_thr", OFS_OUTPUT_THRESHOLD, 16'h00c8);
    expect_reg("blow_t", OFS_BLOW_TIME, 16'h0000);
    expect_reg("status", OFS_STATUS, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      // Odd spacing puts the second read on the other strobe phase
      expect_reg("vac", OFS_VACUUM, 16'h0000);
      @(posedge core_clk_i);
    end
    expect_reg("unmapped", 8'h18, 16'h0000);
    drive(1'b1, 1'b0, 10'h000, 7'b1010000);
    drive(1'b1, 1'b0, 10'h226, 7'b0010101);
    check("bar", {8'h00, bar_o}, 16'h001f);
    drive(1'b1, 1'b0, 10'h227, 7'b0010111);
    drive(1'b1, 1'b0, 10'h1b8, 7'b0010111);
    drive(1'b1, 1'b0, 10'h1b7, 7'b1010101);
    drive(1'b1, 1'b0, 10'h0be, 7'b1010101);
    check("bar", {8'h00, bar_o}, 16'h0001);
    drive(1'b1, 1'b0, 10'h0bd, 7'b1010000);
    drive(1'b1, 1'b0, 10'h0c8, 7'b1010000);
    drive(1'b1, 1'b0, 10'h0c9, 7'b1010101);
    drive(1'b1, 1'b1, 10'h000, 7'b0101000);
    drive(1'b0, 1'b0, 10'h000, 7'b0000000);
    reg_write(OFS_CTRL, 16'h0000);
    drive(1'b0, 1'b0, 10'h000, 7'b1010000);
    drive(1'b1, 1'b0, 10'h000, 7'b0000000);
    reg_write(OFS_CTRL, 16'h0001);
    reg_write(OFS_BLOW_TIME, 16'h0003);
    // Suction still held, so a blow pin that counted would show here
    drive(1'b1, 1'b1, 10'h000, 7'b1010000);
    drive(1'b1, 1'b0, 10'h000, 7'b1010000);
    @(posedge core_clk_i);
    suck_req <= 1'b0;
    cnt = 0;
    for (int i = 0; i < 20 && !blow_valve_o; i++) @(posedge core_clk_i);
    #1;
    while (blow_valve_o && cnt < 100) begin
      @(posedge core_clk_i);
      #1 cnt++;
    end
    // Three ms at ten cycles each, one cycle of slack allowed
    check("blow_len", 16'(cnt == 30 || cnt == 31), 16'h0001);
    reg_write(OFS_BLOW_TIME, 16'h0000);
    reg_write(OFS_CONTROL_THRESHOLD, 16'h00c8);
    expect_reg("ctl_thr", OFS_CONTROL_THRESHOLD, 16'h0226);
    reg_write(OFS_OUTPUT_THRESHOLD, 16'h0226);
    expect_reg("out_thr", OFS_OUTPUT_THRESHOLD, 16'h00c8);
    expect_reg("status", OFS_STATUS, 16'h0021);
    reg_write(OFS_CTRL, 16'h0011);
    expect_reg("status", OFS_STATUS, 16'h0001);
    reg_write(OFS_CONTROL_THRESHOLD, 16'h03ff);
    // At the maximum a live regulation would cut the nozzle here
    drive(1'b1, 1'b0, 10'h3ff, 7'b1010101);
    check("bar", {8'h00, bar_o}, 16'h00ff);
    drive(1'b0, 1'b0, 10'h000, 7'b0000000);
    reg_write(OFS_CTRL, 16'h0003);
    reg_write(OFS_OUTPUT_THRESHOLD, 16'h0064);
    expect_reg("out_thr", OFS_OUTPUT_THRESHOLD, 16'h00c8);
    expect_reg("status", OFS_STATUS, 16'h0029);
    reg_write(OFS_CTRL, 16'h0007);
    // Flash phase is still dark this early in the run
    drive(1'b0, 1'b0, 10'h000, 7'b1010000);
    reg_write(OFS_CTRL, 16'h000b);
    drive(1'b0, 1'b0, 10'h000, 7'b0101000);
    reg_write(OFS_CTRL, 16'h0001);
    reg_write(OFS_OUTPUT_THRESHOLD, 16'h0064);
    expect_reg("out_thr", OFS_OUTPUT_THRESHOLD, 16'h0064);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
